// ===== pkg/pief_pkg.sv
// Behaviour
// [RL1] enable five: eight read-write enables, reset zero, comparators, serial ports, uart two
// [RL2] an enable bit at one passes its source request, at zero blocks it
// [RL3] enable four: logic cell one bit 2, waveform bit 1, oscillator bit 0
// [RL4] enable six: zero-cross bit 2, converter threshold bit 1, conversion bit 0
// [RL5] request zero bit 5 sets on timer zero overflow, held until software clears
// [RL6] request zero bit 4 reads the OR of all port change flags
// [RL7] request zero bit 0 sets on an external event of the selected input
// [RL8] flags set on their event regardless of enable or global enable
// [RL9] software should clear stale flags before setting the matching enable
// [RL10] request one resets zero; bits 5 and 4 read-only, others hardware-set read-write
// [RL11] request one bit 7 sets when timer one gate goes inactive
// [RL12] request one bit 6 sets on a timer one event
// [RL13] request one bit 5 sets on oscillator failure
// [RL14] request one bit 4 sets on a clock switch event
// [RL15] request one bit 3 sets on a clock tuning event
// [RL16] request one bit 2 sets on a memory scanner event
// [RL17] request one bit 0 sets on memory operation done, bit 1 on checksum event
// [RL18] enables four to six and one need peripheral master enable; zero needs global only
// [RL19] one core request: OR of each flag AND its enable, qualified by master enables
package pief_pkg;
	localparam int ADDR_W = 12;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_FLAGS_ZERO = 10'h08C;
	localparam logic [9:0] IDX_FLAGS_ONE = 10'h08D;
	localparam logic [9:0] IDX_EN_ZERO = 10'h096;
	localparam logic [9:0] IDX_EN_ONE = 10'h097;
	localparam logic [9:0] IDX_EN_FOUR = 10'h09A;
	localparam logic [9:0] IDX_EN_FIVE = 10'h09B;
	localparam logic [9:0] IDX_EN_SIX = 10'h09C;
	localparam logic [9:0] IDX_CONTROL = 10'h0A0;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h0A1;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h0A2;
	// request zero fields
	localparam int B_TMR0 = 5;
	localparam int B_PCHG = 4;
	localparam int B_EXT = 0;
	localparam logic [7:0] FLAGS_ZERO_MASK = 8'h31;
	// request one fields
	localparam int B_T1GATE = 7;
	localparam int B_T1 = 6;
	localparam int B_OSCF = 5;
	localparam int B_CSW = 4;
	localparam int B_TUNE = 3;
	localparam int B_SCAN = 2;
	localparam int B_CRC = 1;
	localparam int B_NVM = 0;
	localparam logic [7:0] FLAGS_ONE_RO = 8'h30;
	// control fields
	localparam int B_GLOBAL = 7;
	localparam int B_PERIPH = 6;
	localparam int B_EXT_RISE = 0;
	localparam logic [7:0] CONTROL_MASK = 8'hC1;
	localparam logic [7:0] CONTROL_RESET = 8'h01;
	localparam logic [7:0] EN_FOUR_MASK = 8'h07;
	localparam logic [7:0] EN_SIX_MASK = 8'h07;
	localparam logic [7:0] REG_RESET = 8'h00;
	// irq status events
	localparam int E_GRP_ZERO = 0;
	localparam int E_GRP_ONE = 1;
	localparam int E_GRP_HIGH = 2;
	localparam logic [7:0] IRQ_MASK_BITS = 8'h07;
endpackage

// ===== rtl/pief_top.sv
`timescale 1ns/1ps
module pief_top
	import pief_pkg::*;
#(
	parameter int PCHG_W = 3
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic timer_zero_overflow,
	input wire logic [PCHG_W-1:0] port_change_flags,
	input wire logic external_pin,
	input wire logic timer_one_gate_off,
	input wire logic timer_one_event,
	input wire logic osc_failure,
	input wire logic clock_switch_done,
	input wire logic clock_tuning_event,
	input wire logic memory_scanner_event,
	input wire logic checksum_event,
	input wire logic nonvolatile_done,
	input wire logic [2:0] src_four,
	input wire logic [7:0] src_five,
	input wire logic [2:0] src_six,
	output logic core_irq_req,
	output logic irq
);
	function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [7:0] wr,
		input logic [7:0] keep);
		byte_merge = (old & keep) | (wr & ~keep);
	endfunction

	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [7:0] flags_zero_q;
	logic [7:0] flags_one_q;
	logic [7:0] en_zero_q;
	logic [7:0] en_one_q;
	logic [7:0] en_four_q;
	logic [7:0] en_five_q;
	logic [7:0] en_six_q;
	logic [7:0] control_q;
	logic [7:0] irq_status_q;
	logic [7:0] irq_mask_q;
	logic core_irq_q;
	logic irq_q;
	logic [7:0] flags_zero_d;
	logic [7:0] flags_one_d;
	logic [7:0] irq_status_d;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic ext_level_q;
	logic [2:0] grp_q;

	// bus decode
	wire logic [9:0] idx = paddr[ADDR_W-1:2];
	wire logic aligned = paddr[1:0] == 2'b00;
	wire logic access_done = psel & penable & pready_q;
	// an unaligned access answers with an error and must not write anything
	wire logic wr_en = access_done & pwrite & pstrb[0] & aligned;
	wire logic hit_f0 = idx == IDX_FLAGS_ZERO;
	wire logic hit_f1 = idx == IDX_FLAGS_ONE;
	wire logic hit_e0 = idx == IDX_EN_ZERO;
	wire logic hit_e1 = idx == IDX_EN_ONE;
	wire logic hit_e4 = idx == IDX_EN_FOUR;
	wire logic hit_e5 = idx == IDX_EN_FIVE;
	wire logic hit_e6 = idx == IDX_EN_SIX;
	wire logic hit_ct = idx == IDX_CONTROL;
	wire logic hit_st = idx == IDX_IRQ_STATUS;
	wire logic hit_mk = idx == IDX_IRQ_MASK;
	wire logic mapped = hit_f0 | hit_f1 | hit_e0 | hit_e1 | hit_e4 | hit_e5 | hit_e6
		| hit_ct | hit_st | hit_mk;
	wire logic [7:0] wbyte = pwdata[7:0];

	// external pin: third stage confirms the second before a change counts
	wire logic ext_stable = ext_s2_q == ext_s3_q;
	wire logic ext_new = ext_stable & (ext_s3_q != ext_level_q);
	wire logic ext_edge = ext_new & (ext_s3_q == control_q[B_EXT_RISE]); // RL7

	wire logic pchg_any = |port_change_flags;

	// hardware-set events, independent of any enable
	wire logic [7:0] set_zero = {2'b00, timer_zero_overflow, 3'b000, 1'b0, ext_edge}; // RL5 RL7 RL8
	wire logic [7:0] set_one = {timer_one_gate_off, timer_one_event, 2'b00, // RL8 RL11 RL12
		clock_tuning_event, memory_scanner_event, checksum_event, nonvolatile_done}; // RL15 RL16 RL17

	// set wins over a software clear in the same cycle
	always_comb begin
		flags_zero_d = flags_zero_q | set_zero;
		if (wr_en && hit_f0) begin
			flags_zero_d = (wbyte | set_zero) & FLAGS_ZERO_MASK;
		end
		flags_zero_d[B_PCHG] = pchg_any; // RL6
		flags_zero_d[7:6] = 2'b00;
		flags_zero_d[3:1] = 3'b000;
	end

	always_comb begin
		flags_one_d = flags_one_q | set_one;
		if (wr_en && hit_f1) begin
			flags_one_d = byte_merge(flags_one_q, wbyte, FLAGS_ONE_RO) | set_one; // RL10
		end
		// read-only bits mirror the clock unit's own status
		flags_one_d[B_OSCF] = osc_failure; // RL13
		flags_one_d[B_CSW] = clock_switch_done; // RL14
	end

	// gating toward the core
	wire logic [7:0] pend_zero = flags_zero_q & en_zero_q; // RL2
	wire logic [7:0] pend_one = flags_one_q & en_one_q; // RL2
	wire logic [7:0] pend_four = {5'b00000, src_four} & en_four_q & EN_FOUR_MASK; // RL2 RL3
	wire logic [7:0] pend_five = src_five & en_five_q; // RL1 RL2
	wire logic [7:0] pend_six = {5'b00000, src_six} & en_six_q & EN_SIX_MASK; // RL2 RL4
	wire logic any_zero = |pend_zero;
	wire logic any_one = |pend_one;
	wire logic any_high = |{pend_four, pend_five, pend_six};
	wire logic periph_ok = control_q[B_PERIPH]; // RL18
	wire logic core_req_d = control_q[B_GLOBAL]
		& (any_zero | (periph_ok & (any_one | any_high))); // RL18 RL19

	wire logic [2:0] grp_now = {any_high, any_one, any_zero};
	wire logic [7:0] grp_rise = {5'b00000, grp_now & ~grp_q};

	always_comb begin
		irq_status_d = irq_status_q;
		if (wr_en && hit_st) begin
			irq_status_d = irq_status_q & ~wbyte;
		end
		irq_status_d = (irq_status_d | grp_rise) & IRQ_MASK_BITS;
	end

	// read mux
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		unique case (1'b1)
			hit_f0: rd_byte = flags_zero_q;
			hit_f1: rd_byte = flags_one_q;
			hit_e0: rd_byte = en_zero_q;
			hit_e1: rd_byte = en_one_q;
			hit_e4: rd_byte = en_four_q;
			hit_e5: rd_byte = en_five_q;
			hit_e6: rd_byte = en_six_q;
			hit_ct: rd_byte = control_q;
			hit_st: rd_byte = irq_status_q;
			hit_mk: rd_byte = irq_mask_q;
			default: rd_byte = 8'h00;
		endcase
	end

	// one wait state: answer registered in the first access cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			if (psel && penable && !pready_q) begin
				prdata_q <= (mapped && aligned) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
				pslverr_q <= ~(mapped & aligned);
			end else begin
				// error stands only beside pready
				pslverr_q <= 1'b0;
			end
		end
	end

	wire logic wr_ok = wr_en & aligned;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_zero_q <= REG_RESET;
			flags_one_q <= REG_RESET; // RL10
		end else begin
			flags_zero_q <= flags_zero_d;
			flags_one_q <= flags_one_d;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			en_zero_q <= REG_RESET;
			en_one_q <= REG_RESET;
			en_four_q <= REG_RESET;
			en_five_q <= REG_RESET; // RL1
			en_six_q <= REG_RESET;
			control_q <= CONTROL_RESET;
			irq_mask_q <= REG_RESET;
		end else if (wr_ok) begin
			if (hit_e0) en_zero_q <= wbyte & FLAGS_ZERO_MASK;
			if (hit_e1) en_one_q <= wbyte;
			if (hit_e4) en_four_q <= wbyte & EN_FOUR_MASK; // RL3
			if (hit_e5) en_five_q <= wbyte; // RL1
			if (hit_e6) en_six_q <= wbyte & EN_SIX_MASK; // RL4
			if (hit_ct) control_q <= wbyte & CONTROL_MASK;
			if (hit_mk) irq_mask_q <= wbyte & IRQ_MASK_BITS;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_status_q <= REG_RESET;
			grp_q <= 3'b000;
			core_irq_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			grp_q <= grp_now;
			core_irq_q <= core_req_d; // RL19
			irq_q <= |(irq_status_d & irq_mask_q);
		end
	end

	// ext_level_q starts low, so a pin held high through reset is seen as a rising edge
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			ext_level_q <= 1'b0;
		end else begin
			ext_s1_q <= external_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_stable) ext_level_q <= ext_s3_q;
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign core_irq_req = core_irq_q;
	assign irq = irq_q;
endmodule

// ===== verification/pief_core_model.sv
`timescale 1ns/1ps
module pief_core_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic core_irq_req,
	output logic taken_q
);
	// core samples the level once per clock, so a request must stand a full cycle
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) taken_q <= 1'b0;
		else taken_q <= core_irq_req;
	end
endmodule

// ===== verification/pief_properties.sv
`timescale 1ns/1ps
module pief_checker
	import pief_pkg::*;
#(
	parameter int PCHG_W = 3
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic timer_zero_overflow,
	input wire logic [PCHG_W-1:0] port_change_flags,
	input wire logic osc_failure,
	input wire logic clock_switch_done,
	input wire logic timer_one_event
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire logic rd_end = psel && penable && pready && !pwrite;
	wire logic rd0 = rd_end && paddr == {IDX_FLAGS_ZERO, 2'h0};
	wire logic rd1 = rd_end && paddr == {IDX_FLAGS_ONE, 2'h0};
	setup_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready not on second access edge");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
	unaligned_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> ##1 pslverr)
		else $error("unaligned not refused");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	timer_flag_a: assert property (rd0 && $past(timer_zero_overflow, 2) |-> prdata[B_TMR0])
		else $error("overflow flag missing");
	summary_a: assert property (rd0 |-> prdata[B_PCHG] == $past(|port_change_flags, 2))
		else $error("summary flag wrong");
	mirror_a: assert property (rd1 |-> prdata[5:4] == {$past(osc_failure, 2),
		$past(clock_switch_done, 2)}) else $error("mirror flags wrong");
	tone_flag_a: assert property (rd1 && $past(timer_one_event, 2) |-> prdata[B_T1])
		else $error("timer one flag missing");
	cover property (rd0 && prdata[B_TMR0]);
	cover property (rd1 && prdata[B_OSCF]);
	cover property (pslverr);
endmodule
bind pief_top pief_checker #(.PCHG_W(PCHG_W)) pief_checker_inst (.ref_clk(ref_clk),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.timer_zero_overflow(timer_zero_overflow), .port_change_flags(port_change_flags),
	.osc_failure(osc_failure), .clock_switch_done(clock_switch_done),
	.timer_one_event(timer_one_event));

// ===== verification/tb_peripheral_irq_enable_flags.sv
`timescale 1ns/1ps
module tb_peripheral_irq_enable_flags;
	import pief_pkg::*;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, tz = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdv;
	logic [2:0] pc = '0, s4 = '0, s6 = '0;
	logic [7:0] ev = '0, s5 = '0;
	logic pready, pslverr, core_irq_req, irq, taken_q, err;
	int bad_count = 0, checks_done = 0;
	pief_top pief_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .timer_zero_overflow(tz),
		.port_change_flags(pc), .external_pin(pin), .timer_one_gate_off(ev[7]),
		.timer_one_event(ev[6]), .osc_failure(ev[5]), .clock_switch_done(ev[4]),
		.clock_tuning_event(ev[3]), .memory_scanner_event(ev[2]), .checksum_event(ev[1]),
		.nonvolatile_done(ev[0]), .src_four(s4), .src_five(s5), .src_six(s6),
		.core_irq_req(core_irq_req), .irq(irq));
	pief_core_model pief_core_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
		.core_irq_req(core_irq_req), .taken_q(taken_q));
	initial forever #5 ref_clk = ~ref_clk;
	task automatic report_and_stop();
		if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	// waits for pready however long it takes; only the watchdog ends a hang
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		xfer(1'b1, {i, 2'h0}, d);
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		xfer(1'b0, {i, 2'h0}, 8'h00);
		chk({err, rdv}, {9'h0, 16'h0, e});
	endtask
	// bounded wait on the core request or the summary interrupt
	task automatic wait_lvl(input logic sel, input logic v);
		int n = 0;
		while ((sel ? irq : taken_q) !== v && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		chk(sel ? irq : taken_q, v);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd(IDX_EN_FIVE, 8'h00);
		rd(IDX_FLAGS_ONE, 8'h00);
		rd(IDX_CONTROL, CONTROL_RESET);
		wr(IDX_EN_FIVE, 8'hA5);
		rd(IDX_EN_FIVE, 8'hA5);
		wr(IDX_EN_FOUR, 8'hFF);
		rd(IDX_EN_FOUR, 8'h07);
		wr(IDX_EN_SIX, 8'hFF);
		rd(IDX_EN_SIX, 8'h07);
		xfer(1'b0, 12'h004, 8'h00);
		chk(err, 1'b1);
		// unaligned write is refused and must leave the register untouched
		xfer(1'b1, {IDX_EN_FIVE, 2'h2}, 8'h5A);
		chk(err, 1'b1);
		rd(IDX_EN_FIVE, 8'hA5);
		tz <= 1'b1;
		rd(IDX_FLAGS_ZERO, 8'h20);
		tz <= 1'b0;
		rd(IDX_FLAGS_ZERO, 8'h20);
		wr(IDX_FLAGS_ZERO, 8'h00);
		pc <= 3'b010;
		rd(IDX_FLAGS_ZERO, 8'h10);
		wr(IDX_FLAGS_ZERO, 8'h00);
		rd(IDX_FLAGS_ZERO, 8'h10);
		pc <= 3'b000;
		rd(IDX_FLAGS_ZERO, 8'h00);
		pin <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rd(IDX_FLAGS_ZERO, 8'h01);
		wr(IDX_FLAGS_ZERO, 8'h00);
		for (int i = 0; i < 8; i++) begin
			ev <= 8'h01 << i;
			@(posedge ref_clk);
			rd(IDX_FLAGS_ONE, 8'h01 << i);
			// bits 5 and 4 mirror a level, so the source is held through the clear
			if (i != 4 && i != 5) ev <= 8'h00;
			wr(IDX_FLAGS_ONE, 8'h00);
			rd(IDX_FLAGS_ONE, (i == 4 || i == 5) ? 8'h01 << i : 8'h00);
			ev <= 8'h00;
			@(posedge ref_clk);
		end
		wr(IDX_FLAGS_ONE, 8'h00);
		wr(IDX_EN_ONE, 8'h40);
		wr(IDX_CONTROL, 8'hC1);
		ev <= 8'h40;
		@(posedge ref_clk);
		ev <= 8'h00;
		wait_lvl(1'b0, 1'b1);
		wr(IDX_FLAGS_ONE, 8'h00);
		wait_lvl(1'b0, 1'b0);
		wr(IDX_EN_FIVE, 8'h00);
		s5 <= 8'h80;
		repeat (4) @(posedge ref_clk);
		chk(taken_q, 1'b0);
		wr(IDX_EN_FIVE, 8'h80);
		wait_lvl(1'b0, 1'b1);
		wr(IDX_CONTROL, 8'h81);
		wait_lvl(1'b0, 1'b0);
		wr(IDX_CONTROL, 8'hC1);
		wr(IDX_IRQ_STATUS, 8'h07);
		wr(IDX_IRQ_MASK, 8'h04);
		rd(IDX_IRQ_MASK, 8'h04);
		rd(IDX_IRQ_STATUS, 8'h00);
		s5 <= 8'h00;
		repeat (3) @(posedge ref_clk);
		s5 <= 8'h80;
		wait_lvl(1'b1, 1'b1);
		rd(IDX_IRQ_STATUS, 8'h04);
		wr(IDX_IRQ_STATUS, 8'h04);
		wait_lvl(1'b1, 1'b0);
		s5 <= 8'h00;
		wait_lvl(1'b0, 1'b0);
		wr(IDX_EN_FOUR, 8'h03);
		s4 <= 3'b100;
		repeat (4) @(posedge ref_clk);
		chk(taken_q, 1'b0);
		wr(IDX_EN_FOUR, 8'h04);
		wait_lvl(1'b0, 1'b1);
		s4 <= 3'b000;
		wait_lvl(1'b0, 1'b0);
		wr(IDX_EN_SIX, 8'h06);
		s6 <= 3'b001;
		repeat (4) @(posedge ref_clk);
		chk(taken_q, 1'b0);
		wr(IDX_EN_SIX, 8'h01);
		wait_lvl(1'b0, 1'b1);
		report_and_stop();
	end
	initial begin
		#50us;
		bad_count++;
		report_and_stop();
	end
endmodule
